// ==== dfr_params.svh ====
// Purpose: Offsets, field positions, reset values and widths of the feedback register bank.
// Assumes: Byte-wide register port, little-endian byte lanes inside each register.
// Notes:   Definitions only.
`ifndef DFR_PARAMS_SVH
`define DFR_PARAMS_SVH

// ****************************************************************
// Register port
// ****************************************************************
`define DFR_ADDR_W          6
`define DFR_OFS_INT         6'h00
`define DFR_OFS_CORR        6'h02
`define DFR_OFS_PHASE       6'h04
`define DFR_OFS_FREQ        6'h08
`define DFR_OFS_NUM         6'h10
`define DFR_OFS_DEN         6'h18

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define DFR_INT_W           14
`define DFR_CORR_W          10
`define DFR_PHASE_W         30
`define DFR_FREQ_W          29
`define DFR_FRAC_W          48
`define DFR_FINE_W          31
`define DFR_MULT_W          7
`define DFR_PEC_DLY_ONE     2'h1
`define DFR_PHASE_TRIG_LANE 3'h3
`define DFR_FREQ_TRIG_LANE  3'h3
`define DFR_FRAC_TRIG_LANE  3'h5

// ****************************************************************
// Reset values
// ****************************************************************
`define DFR_INT_RST         14'h0190
`define DFR_CORR_RST        10'h000
`define DFR_PHASE_RST       30'h00000000
`define DFR_FREQ_RST        29'h00000000
`define DFR_NUM_RST         48'h000000000000
`define DFR_DEN_RST         48'h000000800000

`endif

// ==== dfr_pkg.sv ====
// Purpose: Types shared by the feedback register bank and its correction datapath.
// Assumes: dfr_params.svh supplies the widths.
// Notes:   Field order of dfr_corr_t matches the register layout.
`include "dfr_params.svh"

package dfr_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [`DFR_INT_W-1:0]  feedback_integer;
    logic [`DFR_FRAC_W-1:0] feedback_numerator;
    logic [`DFR_FRAC_W-1:0] feedback_denominator;
  } dfr_fb_t;

  typedef struct packed {
    logic                   fine_rev;
    logic [1:0]             pec_delay;
    logic [`DFR_MULT_W-1:0] corr_mult;
  } dfr_corr_t;

endpackage : dfr_pkg

// ==== dfr_corr_path.sv ====
// Purpose: Fine timestamp ordering and sigma-delta error delay of the feedback correction path.
// Assumes: Inputs synchronous to clk.
// Notes:   All outputs are registered.
`include "dfr_params.svh"

module dfr_corr_path #(
  parameter int SDM_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire dfr_pkg::dfr_corr_t      cfg,
  input  wire logic [`DFR_FINE_W-1:0]  fine_in,
  input  wire logic [SDM_W-1:0]        sdm_in,
  output logic      [`DFR_FINE_W-1:0]  fine_out,
  output logic      [SDM_W-1:0]        sdm_out
);
  import dfr_pkg::*;

  logic [`DFR_FINE_W-1:0] rev_w;
  logic [`DFR_FINE_W-1:0] fine_nxt;
  logic [SDM_W-1:0]       sdm_d1_r;
  logic [SDM_W-1:0]       sdm_d1_nxt;
  logic [SDM_W-1:0]       sdm_nxt;

  // ****************************************************************
  // Datapath
  // ****************************************************************
  for (genvar i = 0; i < `DFR_FINE_W; i++) begin : g_rev
    assign rev_w[`DFR_FINE_W-1-i] = fine_in[i];
  end

  always_comb begin
    fine_nxt   = cfg.fine_rev ? rev_w : fine_in;  // [RQ4]
    sdm_d1_nxt = sdm_in;
    sdm_nxt    = (cfg.pec_delay == `DFR_PEC_DLY_ONE) ? sdm_d1_r : sdm_in;  // [RQ5]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fine_out <= '0;
      sdm_d1_r <= '0;
      sdm_out  <= '0;
    end else begin
      fine_out <= fine_nxt;
      sdm_d1_r <= sdm_d1_nxt;
      sdm_out  <= sdm_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_delay_held;
    (cfg.pec_delay == `DFR_PEC_DLY_ONE) ##1 (cfg.pec_delay == `DFR_PEC_DLY_ONE);
  endsequence

  property p_rev;
    @(posedge clk) disable iff (rst)
    cfg.fine_rev |=> fine_out == $past(rev_w);
  endproperty
  a_rev: assert property (p_rev) else $error("Fine timestamp not reversed.");  // [RQ4]

  property p_straight;
    @(posedge clk) disable iff (rst)
    !cfg.fine_rev |=> fine_out == $past(fine_in);
  endproperty
  a_straight: assert property (p_straight) else $error("Fine timestamp not passed.");  // [RQ4]

  property p_dly;
    @(posedge clk) disable iff (rst)
    s_delay_held |=> sdm_out == $past(sdm_in, 2);
  endproperty
  a_dly: assert property (p_dly) else $error("Error not delayed one cycle.");  // [RQ5]

  property p_nodly;
    @(posedge clk) disable iff (rst)
    (cfg.pec_delay != `DFR_PEC_DLY_ONE) |=> sdm_out == $past(sdm_in);
  endproperty
  a_nodly: assert property (p_nodly) else $error("Error delayed unexpectedly.");  // [RQ5]

endmodule // dfr_corr_path

// ==== dfr_regs.sv ====
// Purpose: Feedback divider, correction, phase offset and frequency word registers of the DPLL.
// Assumes: Byte-wide register port synchronous to clk; one access per cycle.
// Notes:   Applied values and apply pulses leave on registered outputs.
//
// Operation
// [RQ1] 14-bit integer field, reset 0x190, top reserved.
// [RQ2] Software keeps feedback clock at most 33 MHz.
// [RQ3] Changed integer applies integer, numerator, denominator together.
// [RQ4] Bit 9 reverses the fine timestamp lines.
// [RQ5] Delay field value one delays error one cycle.
// [RQ6] Software sets remainder multiplier from denominator bits.
// [RQ7] Phase offset is 30-bit two's complement field.
// [RQ8] Phase offset applies when byte 31:24 written.
// [RQ9] Phase offset ignored while hitless switching enabled.
// [RQ10] One phase offset moves all outputs together.
// [RQ11] Frequency word is 29-bit two's complement field.
// [RQ12] Frequency word applies when top byte written.
// [RQ13] Fraction top byte write applies whole group.
// [RQ14] Software normalises fraction so denominator top bit set.
// [RQ15] Lower bytes wait in shadow until trigger.
`include "dfr_params.svh"

module dfr_regs #(
  parameter int SDM_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [`DFR_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    hitless_switch_en,
  input  wire logic [`DFR_FINE_W-1:0]  tdc_fine,
  input  wire logic [SDM_W-1:0]        sdm_err,
  output dfr_pkg::dfr_fb_t             fb_div,
  output logic                         fb_apply,
  output logic      [`DFR_PHASE_W-1:0] phase_shift,
  output logic                         phase_apply,
  output logic      [`DFR_FREQ_W-1:0]  freq_word,
  output logic                         freq_apply,
  output dfr_pkg::dfr_corr_t           corr_cfg,
  output logic      [`DFR_FINE_W-1:0]  fine_ts,
  output logic      [SDM_W-1:0]        sdm_err_corr
);
  import dfr_pkg::*;

  localparam logic [`DFR_ADDR_W-1:0] OFS_INT   = `DFR_OFS_INT;
  localparam logic [`DFR_ADDR_W-1:0] OFS_CORR  = `DFR_OFS_CORR;
  localparam logic [`DFR_ADDR_W-1:0] OFS_PHASE = `DFR_OFS_PHASE;
  localparam logic [`DFR_ADDR_W-1:0] OFS_FREQ  = `DFR_OFS_FREQ;
  localparam logic [`DFR_ADDR_W-1:0] OFS_NUM   = `DFR_OFS_NUM;
  localparam logic [`DFR_ADDR_W-1:0] OFS_DEN   = `DFR_OFS_DEN;

  logic [`DFR_INT_W-1:0]   int_r;
  logic [`DFR_INT_W-1:0]   int_nxt;
  dfr_corr_t               corr_nxt;
  logic [`DFR_PHASE_W-1:0] phase_r;
  logic [`DFR_PHASE_W-1:0] phase_nxt;
  logic [`DFR_FREQ_W-1:0]  freq_r;
  logic [`DFR_FREQ_W-1:0]  freq_nxt;
  logic [`DFR_FRAC_W-1:0]  num_r;
  logic [`DFR_FRAC_W-1:0]  num_nxt;
  logic [`DFR_FRAC_W-1:0]  den_r;
  logic [`DFR_FRAC_W-1:0]  den_nxt;
  dfr_fb_t                 fb_nxt;
  logic                    fb_apply_nxt;
  logic [`DFR_PHASE_W-1:0] phase_app_r;
  logic [`DFR_PHASE_W-1:0] phase_app_nxt;
  logic [`DFR_PHASE_W-1:0] phase_out_nxt;
  logic                    phase_apply_nxt;
  logic [`DFR_FREQ_W-1:0]  freq_out_nxt;
  logic                    freq_apply_nxt;
  logic [7:0]              rdata_nxt;
  logic                    sel_int;
  logic                    sel_corr;
  logic                    sel_phase;
  logic                    sel_freq;
  logic                    sel_num;
  logic                    sel_den;
  logic [2:0]              lane;
  logic                    phase_trig;
  logic                    freq_trig;
  logic                    frac_trig;
  logic [63:0]             t64;
  logic [63:0]             rd64;

  function automatic logic [63:0] put_byte(input logic [63:0] v,
                                           input logic [2:0]  ln,
                                           input logic [7:0]  d);
    logic [63:0] r;
    r                  = v;
    r[{ln, 3'h0} +: 8] = d;
    return r;
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    sel_int    = reg_addr[`DFR_ADDR_W-1:1] == OFS_INT[`DFR_ADDR_W-1:1];
    sel_corr   = reg_addr[`DFR_ADDR_W-1:1] == OFS_CORR[`DFR_ADDR_W-1:1];
    sel_phase  = reg_addr[`DFR_ADDR_W-1:2] == OFS_PHASE[`DFR_ADDR_W-1:2];
    sel_freq   = reg_addr[`DFR_ADDR_W-1:2] == OFS_FREQ[`DFR_ADDR_W-1:2];
    sel_num    = reg_addr[`DFR_ADDR_W-1:3] == OFS_NUM[`DFR_ADDR_W-1:3];
    sel_den    = reg_addr[`DFR_ADDR_W-1:3] == OFS_DEN[`DFR_ADDR_W-1:3];
    lane       = reg_addr[2:0];
    phase_trig = reg_wr && sel_phase && ({1'b0, lane[1:0]} == `DFR_PHASE_TRIG_LANE);  // [RQ8]
    freq_trig  = reg_wr && sel_freq && ({1'b0, lane[1:0]} == `DFR_FREQ_TRIG_LANE);  // [RQ12]
    frac_trig  = reg_wr && (sel_num || sel_den) && (lane == `DFR_FRAC_TRIG_LANE);  // [RQ13]
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    int_nxt   = int_r;
    corr_nxt  = corr_cfg;
    phase_nxt = phase_r;
    freq_nxt  = freq_r;
    num_nxt   = num_r;
    den_nxt   = den_r;
    t64       = '0;
    if (reg_wr && sel_int) begin
      t64     = put_byte(64'(int_r), {2'h0, lane[0]}, reg_wdata);
      int_nxt = t64[`DFR_INT_W-1:0];  // [RQ1]
    end
    if (reg_wr && sel_corr) begin
      t64      = put_byte(64'(corr_cfg), {2'h0, lane[0]}, reg_wdata);
      corr_nxt = t64[`DFR_CORR_W-1:0];
    end
    if (reg_wr && sel_phase) begin
      t64       = put_byte(64'(phase_r), {1'b0, lane[1:0]}, reg_wdata);
      phase_nxt = t64[`DFR_PHASE_W-1:0];  // [RQ7] [RQ15]
    end
    if (reg_wr && sel_freq) begin
      t64      = put_byte(64'(freq_r), {1'b0, lane[1:0]}, reg_wdata);
      freq_nxt = t64[`DFR_FREQ_W-1:0];  // [RQ11] [RQ15]
    end
    if (reg_wr && sel_num) begin
      t64     = put_byte(64'(num_r), lane, reg_wdata);
      num_nxt = t64[`DFR_FRAC_W-1:0];
    end
    if (reg_wr && sel_den) begin
      t64     = put_byte(64'(den_r), lane, reg_wdata);
      den_nxt = t64[`DFR_FRAC_W-1:0];
    end
  end

  // ****************************************************************
  // Atomic apply
  // ****************************************************************
  always_comb begin
    fb_nxt          = fb_div;
    fb_apply_nxt    = 1'b0;
    if ((reg_wr && sel_int && (int_nxt != int_r)) || frac_trig) begin  // [RQ3] [RQ13]
      fb_nxt       = '{feedback_integer: int_nxt, feedback_numerator: num_nxt,
                       feedback_denominator: den_nxt};
      fb_apply_nxt = 1'b1;
    end
    phase_app_nxt   = phase_trig ? phase_nxt : phase_app_r;  // [RQ8] [RQ15]
    phase_apply_nxt = phase_trig && !hitless_switch_en;  // [RQ9]
    phase_out_nxt   = hitless_switch_en ? '0 : phase_app_nxt;  // [RQ9] [RQ10]
    freq_apply_nxt  = freq_trig;  // [RQ12]
    freq_out_nxt    = freq_trig ? freq_nxt : freq_word;  // [RQ12] [RQ15]
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rd64 = '0;
    if (sel_int) begin
      rd64 = 64'(int_r);  // [RQ1]
    end else if (sel_corr) begin
      rd64 = 64'(corr_cfg);
    end else if (sel_phase) begin
      rd64 = 64'(phase_r);
    end else if (sel_freq) begin
      rd64 = 64'(freq_r);
    end else if (sel_num) begin
      rd64 = 64'(num_r);
    end else if (sel_den) begin
      rd64 = 64'(den_r);
    end
    if (sel_int || sel_corr) begin
      rdata_nxt = rd64[{2'h0, lane[0], 3'h0} +: 8];
    end else if (sel_phase || sel_freq) begin
      rdata_nxt = rd64[{1'b0, lane[1:0], 3'h0} +: 8];
    end else begin
      rdata_nxt = rd64[{lane, 3'h0} +: 8];
    end
    if (!reg_rd) begin
      rdata_nxt = reg_rdata;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_r       <= `DFR_INT_RST;
      corr_cfg    <= `DFR_CORR_RST;
      phase_r     <= `DFR_PHASE_RST;
      freq_r      <= `DFR_FREQ_RST;
      num_r       <= `DFR_NUM_RST;
      den_r       <= `DFR_DEN_RST;
      fb_div      <= '{feedback_integer: `DFR_INT_RST, feedback_numerator: `DFR_NUM_RST,
                       feedback_denominator: `DFR_DEN_RST};
      fb_apply    <= 1'b0;
      phase_app_r <= `DFR_PHASE_RST;
      phase_shift <= `DFR_PHASE_RST;
      phase_apply <= 1'b0;
      freq_word   <= `DFR_FREQ_RST;
      freq_apply  <= 1'b0;
      reg_rdata   <= 8'h00;
      reg_rvalid  <= 1'b0;
    end else begin
      int_r       <= int_nxt;
      corr_cfg    <= corr_nxt;
      phase_r     <= phase_nxt;
      freq_r      <= freq_nxt;
      num_r       <= num_nxt;
      den_r       <= den_nxt;
      fb_div      <= fb_nxt;
      fb_apply    <= fb_apply_nxt;
      phase_app_r <= phase_app_nxt;
      phase_shift <= phase_out_nxt;
      phase_apply <= phase_apply_nxt;
      freq_word   <= freq_out_nxt;
      freq_apply  <= freq_apply_nxt;
      reg_rdata   <= rdata_nxt;
      reg_rvalid  <= reg_rd;
    end
  end

  // ****************************************************************
  // Correction datapath
  // ****************************************************************
  dfr_corr_path #(
    .SDM_W (SDM_W)
  ) u_corr (
    .clk      (clk),
    .rst      (rst),
    .cfg      (corr_cfg),
    .fine_in  (tdc_fine),
    .sdm_in   (sdm_err),
    .fine_out (fine_ts),
    .sdm_out  (sdm_err_corr)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_phase_trig;
    phase_trig && !hitless_switch_en;
  endsequence

  sequence s_phase_done;
    phase_apply && (phase_shift == $past(phase_nxt));
  endsequence

  property p_int_apply;
    (reg_wr && sel_int && (int_nxt != int_r)) |=>
      fb_apply && (fb_div.feedback_integer == $past(int_nxt))
      && (fb_div.feedback_numerator == $past(num_r));
  endproperty
  a_int_apply: assert property (p_int_apply) else $error("Integer change not applied.");  // [RQ3]

  property p_int_same;
    (reg_wr && sel_int && (int_nxt == int_r)) |=> !fb_apply && $stable(fb_div);
  endproperty
  a_int_same: assert property (p_int_same) else $error("Unchanged integer applied.");  // [RQ3]

  property p_frac;
    frac_trig |=> fb_apply && (fb_div.feedback_numerator == $past(num_nxt))
                  && (fb_div.feedback_denominator == $past(den_nxt));
  endproperty
  a_frac: assert property (p_frac) else $error("Fraction group not applied.");  // [RQ13]

  property p_phase_apply;
    s_phase_trig |=> s_phase_done;
  endproperty
  a_phase_apply: assert property (p_phase_apply) else $error("Phase offset not applied.");  // [RQ8]

  property p_phase_low;
    (reg_wr && sel_phase && !phase_trig) |=> !phase_apply && $stable(phase_app_r);
  endproperty
  a_phase_low: assert property (p_phase_low) else $error("Phase low byte leaked.");  // [RQ15]

  property p_hitless;
    hitless_switch_en |=> (phase_shift == '0) && !phase_apply;
  endproperty
  a_hitless: assert property (p_hitless) else $error("Phase used during hitless switch.");  // [RQ9]

  property p_freq_apply;
    freq_trig |=> freq_apply && (freq_word == $past(freq_nxt));
  endproperty
  a_freq_apply: assert property (p_freq_apply) else $error("Frequency word not applied.");  // [RQ12]

  property p_freq_low;
    !freq_trig |=> !freq_apply && $stable(freq_word);
  endproperty
  a_freq_low: assert property (p_freq_low) else $error("Frequency changed without trigger.");  // [RQ12]

  property p_int_read;
    (reg_rd && (reg_addr == OFS_INT + 6'h01)) |=>
      reg_rvalid && (reg_rdata[7:6] == 2'h0) && (reg_rdata[5:0] == $past(int_r[13:8]));
  endproperty
  a_int_read: assert property (p_int_read) else $error("Integer high byte misread.");  // [RQ1]

endmodule // dfr_regs

// ==== dfr_regs_test.sv ====
// Purpose: Self-checking bench of the feedback register bank.
// Assumes: dfr_pkg and dfr_regs are compiled first; byte map as in dfr_params.svh.
// Notes:   Inputs change on the falling edge, where outputs are also sampled.
`include "dfr_params.svh"

module dfr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dfr_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int SDM_W = 16;
  logic                    clk;
  logic                    rst;
  logic [`DFR_ADDR_W-1:0]  reg_addr;
  logic [7:0]              reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  logic                    reg_rvalid;
  logic                    hitless_switch_en;
  logic [`DFR_FINE_W-1:0]  tdc_fine;
  logic [SDM_W-1:0]        sdm_err;
  dfr_fb_t                 fb_div;
  logic                    fb_apply;
  logic [`DFR_PHASE_W-1:0] phase_shift;
  logic                    phase_apply;
  logic [`DFR_FREQ_W-1:0]  freq_word;
  logic                    freq_apply;
  dfr_corr_t               corr_cfg;
  logic [`DFR_FINE_W-1:0]  fine_ts;
  logic [SDM_W-1:0]        sdm_err_corr;
  int                      n_errors = 0;
  int                      n_compared = 0;

  // ****************************************
  // Design
  // ****************************************
  dfr_regs #(.SDM_W(SDM_W)) i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .hitless_switch_en(hitless_switch_en), .tdc_fine(tdc_fine), .sdm_err(sdm_err),
    .fb_div(fb_div), .fb_apply(fb_apply), .phase_shift(phase_shift),
    .phase_apply(phase_apply), .freq_word(freq_word), .freq_apply(freq_apply),
    .corr_cfg(corr_cfg), .fine_ts(fine_ts), .sdm_err_corr(sdm_err_corr)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_rd    = 1'b0;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
  endtask

  task automatic idle();
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_wr   = 1'b0;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1, "read valid");
    chk(reg_rdata, exp, "read data");
  endtask

  function automatic logic [30:0] rev(input logic [30:0] v);
    for (int i = 0; i < 31; i++)
      rev[30-i] = v[i];
  endfunction

  function automatic logic [30:0] fval(input int k);
    return 31'h0ABCDEF1 + 31'(k) * 31'h01010101;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    chk(fb_div, {`DFR_INT_RST, `DFR_NUM_RST, `DFR_DEN_RST}, "reset group");
    rd(`DFR_OFS_INT, 8'h90);
    rd(`DFR_OFS_INT + 6'h01, 8'h01);
    for (int a = 2; a < 12; a++)
      rd(6'(a), 8'h00);
    wr(6'h0C, 8'hAA);
    idle();
    rd(6'h0C, 8'h00);
  endtask

  task automatic test_integer();
    wr(`DFR_OFS_INT + 6'h01, 8'hFF);
    idle();
    chk(fb_apply, 1'b1, "integer apply");
    chk(fb_div.feedback_integer, 14'h3F90, "integer value");
    rd(`DFR_OFS_INT + 6'h01, 8'h3F);
    chk(fb_apply, 1'b0, "apply pulse length");
    wr(`DFR_OFS_INT + 6'h01, 8'h3F);
    wr(`DFR_OFS_INT, 8'h90);
    idle();
    chk(fb_apply, 1'b0, "unchanged integer");
    wr(`DFR_OFS_INT, 8'h91);
    idle();
    chk(fb_apply, 1'b1, "low byte apply");
    chk(fb_div.feedback_integer, 14'h3F91, "low byte value");
  endtask

  task automatic test_fraction();
    for (int b = 0; b < 5; b++)
      wr(`DFR_OFS_DEN + 6'(b), 8'h00);
    wr(`DFR_OFS_DEN + 6'h05, 8'hC0);
    idle();
    chk(fb_apply, 1'b1, "den trigger");
    chk(fb_div, {14'h3F91, 48'h0, 48'hC00000000000}, "den group");
    for (int b = 0; b < 5; b++)
      wr(`DFR_OFS_NUM + 6'(b), 8'(8'h11 + b));
    wr(`DFR_OFS_NUM + 6'h06, 8'hFF);
    idle();
    chk(fb_apply, 1'b0, "num low bytes");
    chk(fb_div.feedback_numerator, 48'h0, "num shadowed");
    wr(`DFR_OFS_NUM + 6'h05, 8'h80);
    idle();
    chk(fb_apply, 1'b1, "num trigger");
    chk(fb_div, {14'h3F91, 48'h801514131211, 48'hC00000000000}, "num group");
    rd(`DFR_OFS_NUM + 6'h06, 8'h00);
  endtask

  task automatic test_phase();
    wr(`DFR_OFS_PHASE, 8'h78);
    wr(`DFR_OFS_PHASE + 6'h01, 8'h56);
    wr(`DFR_OFS_PHASE + 6'h02, 8'h34);
    idle();
    chk(phase_apply, 1'b0, "phase low bytes");
    chk(phase_shift, 30'h0, "phase shadowed");
    wr(`DFR_OFS_PHASE + 6'h03, 8'hE2);
    idle();
    chk(phase_apply, 1'b1, "phase trigger");
    chk(phase_shift, 30'h22345678, "phase value");
    rd(`DFR_OFS_PHASE + 6'h03, 8'h22);
    hitless_switch_en = 1'b1;
    wr(`DFR_OFS_PHASE, 8'h01);
    wr(`DFR_OFS_PHASE + 6'h03, 8'h00);
    idle();
    chk(phase_apply, 1'b0, "hitless pulse");
    chk(phase_shift, 30'h0, "hitless value");
    hitless_switch_en = 1'b0;
    @(negedge clk);
    chk(phase_shift, 30'h00345601, "after hitless");
  endtask

  task automatic test_freq();
    wr(`DFR_OFS_FREQ, 8'hEF);
    wr(`DFR_OFS_FREQ + 6'h01, 8'hCD);
    wr(`DFR_OFS_FREQ + 6'h02, 8'hAB);
    idle();
    chk(freq_apply, 1'b0, "freq low bytes");
    chk(freq_word, 29'h0, "freq shadowed");
    wr(`DFR_OFS_FREQ + 6'h03, 8'hFF);
    idle();
    chk(freq_apply, 1'b1, "freq trigger");
    chk(freq_word, 29'h1FABCDEF, "freq value");
    rd(`DFR_OFS_FREQ + 6'h03, 8'h1F);
  endtask

  task automatic test_corr();
    logic [1:0] pec;
    for (int m = 0; m < 4; m++) begin
      pec = 2'(m);
      wr(`DFR_OFS_CORR, {pec[0], 7'h55});
      wr(`DFR_OFS_CORR + 6'h01, {6'h3F, pec[1], pec[1]});
      idle();
      chk(corr_cfg, {pec[1], pec, 7'h55}, "corr fields");
      rd(`DFR_OFS_CORR + 6'h01, {6'h00, pec[1], pec[1]});
      for (int k = 0; k < 7; k++) begin
        @(negedge clk);
        if (k >= 3) begin
          chk(fine_ts, pec[1] ? rev(fval(k - 1)) : fval(k - 1), "fine order");
          chk(sdm_err_corr, 16'(16'hA000 + ((pec == `DFR_PEC_DLY_ONE) ? k - 2 : k - 1)),
              "sdm delay");
        end
        tdc_fine = fval(k);
        sdm_err  = 16'(16'hA000 + k);
      end
    end
  endtask

  task automatic test_rerst();
    @(negedge clk);
    rst = 1'b1;
    idle();
    rst = 1'b0;
    chk(fb_div, {`DFR_INT_RST, `DFR_NUM_RST, `DFR_DEN_RST}, "second reset");
    rd(`DFR_OFS_INT + 6'h01, 8'h01);
  endtask

  // ****************************************
  // Main
  // ****************************************
  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst               = 1'b1;
    reg_addr          = '0;
    reg_wdata         = '0;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    hitless_switch_en = 1'b0;
    tdc_fine          = '0;
    sdm_err           = '0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_integer();
    test_fraction();
    test_phase();
    test_freq();
    test_corr();
    test_rerst();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

endmodule // dfr_regs_test
